// [pkg/pifm_pkg.sv]
`default_nettype none
package pifm_pkg;
  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int NUM_IN = 8;
  localparam int NUM_OUT = 8;
  localparam int CODE_W = 16;
  localparam int DELAY_W = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_TIME_NS = 1000000;
  localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register byte offsets, each register one 32-bit word
  // ----------------------------------------------------------------
  localparam logic [7:0] IN_CFG_BASE = 8'h00;
  localparam logic [7:0] IN_DLY_BASE = 8'h20;
  localparam logic [7:0] OUT_CFG_BASE = 8'h40;
  localparam logic [7:0] STATUS_OFS = 8'h60;
  localparam logic [7:0] CONTROL_OFS = 8'h64;
  localparam int POL_BIT = 16;
  localparam int LOAD_DEFAULTS_BIT = 0;

  // ----------------------------------------------------------------
  // Function codes, stored as four decimal digits in hex nibbles
  // ----------------------------------------------------------------
  localparam logic [15:0] FN_UNUSED = 16'h0000;
  localparam logic [15:0] FN_REMOTE_START = 16'h2032;
  localparam logic [15:0] FN_MAN_START = 16'h2033;
  localparam logic [15:0] FN_MAN_STOP = 16'h2034;
  localparam logic [15:0] FN_EMERGENCY = 16'h4201;
  localparam logic [15:0] FN_HORN = 16'h3152;
  localparam logic [15:0] FN_OFFLINE = 16'h3156;

  // ----------------------------------------------------------------
  // Values after reset or after a load of defaults
  // ----------------------------------------------------------------
  localparam logic [NUM_IN*16-1:0] IN_FUNC_RESET = {
    FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED,
    FN_MAN_STOP, FN_MAN_START, FN_REMOTE_START, FN_EMERGENCY};
  localparam logic [NUM_OUT*16-1:0] OUT_FUNC_RESET = {
    FN_HORN, FN_OFFLINE, FN_UNUSED, FN_UNUSED,
    FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED};
  localparam logic [15:0] IN_DELAY_RESET = 16'h0000;
  localparam logic [31:0] BUS_WORD_RESET = 32'h0000_0000;
endpackage : pifm_pkg
`default_nettype wire

// [logic/pifm_input_qualifier.sv]
`timescale 1ns/1ps
`default_nettype none
module pifm_input_qualifier
  import pifm_pkg::*;
#(
  parameter int DW = DELAY_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic rawIn,
  input wire logic invert,
  input wire logic tickEn,
  input wire logic [DW-1:0] delay,
  input wire logic delayOnRelease,
  output logic qualified
);
  logic level;
  logic qual_q;
  logic [DW-1:0] cnt_q;

  // Polarity acts on the raw pin, ahead of any timing.
  assign level = rawIn ^ invert;
  assign qualified = qual_q;

  // The counter restarts whenever the level returns to the accepted one,
  // so a glitch shorter than the delay less one tick never reaches the commands, except a release on an input whose release is immediate.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      qual_q <= 1'b0;
      cnt_q <= '0;
    end else if (level == qual_q) begin
      cnt_q <= '0;
    end else if (!level && !delayOnRelease) begin
      qual_q <= 1'b0;
      cnt_q <= '0;
    end else if (cnt_q >= delay) begin
      qual_q <= level;
      cnt_q <= '0;
    end else if (tickEn) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence releaseSeen;
    qual_q && !level;
  endsequence

  fast_release_a: assert property (@(posedge sys_clk) disable iff (srst)
    releaseSeen and !delayOnRelease |=> !qual_q)
    else $error("Release without delay did not clear in one cycle.");

  held_release_a: assert property (@(posedge sys_clk) disable iff (srst)
    releaseSeen and delayOnRelease && delay != '0 && cnt_q == '0 |=> qual_q)
    else $error("Delayed release cleared too early.");

  held_activate_a: assert property (@(posedge sys_clk) disable iff (srst)
    !qual_q && level && delay != '0 && cnt_q == '0 |=> !qual_q)
    else $error("Activation ignored the configured delay.");

  zero_delay_a: assert property (@(posedge sys_clk) disable iff (srst)
    !qual_q && level && delay == '0 |=> qual_q)
    else $error("Activation with zero delay was not immediate.");
endmodule : pifm_input_qualifier
`default_nettype wire

// [logic/pifm_panel_io.sv]
// Contract
// - Eight inputs, each with its own function, delay and polarity.
// - Code 0000 ignored; code 2032 requests remote start, delayed both ways.
// - Codes 2033, 2034, 4201 delay activation only; release is immediate.
// - Input commands are forwarded to the controller over the active link.
// - Defaults: inputs 1..4 carry 4201, 2032, 2033, 2034.
// - Each output has its own function and polarity.
// - Eight outputs; 0000 unused, 3152 horn, 3156 offline; defaults 7=3156, 8=3152.
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pifm_panel_io
  import pifm_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES,
  parameter int NIN = NUM_IN,
  parameter int NOUT = NUM_OUT
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [NIN-1:0] inPins,
  output logic [NOUT-1:0] outPins,
  input wire logic linkOnline,
  input wire logic hornRequest,
  output logic cmdRemoteStart,
  output logic cmdManualStart,
  output logic cmdManualStop,
  output logic cmdEmergencyStop
);
  // ----------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------
  logic [CODE_W-1:0] inFunc_q [NIN];
  logic [DELAY_W-1:0] inDelay_q [NIN];
  logic [NIN-1:0] inPol_q;
  logic [CODE_W-1:0] outFunc_q [NOUT];
  logic [NOUT-1:0] outPol_q;
  logic [NIN-1:0] inQual;
  logic [NOUT-1:0] outResult;
  logic [NOUT-1:0] outPins_q;
  logic waitReq_q;
  logic [31:0] rdData_q;
  logic [31:0] rdData_d;
  logic wrDo;
  logic loadDefaults;
  logic [2:0] regIdx;
  logic [31:0] tickCnt_q;
  logic tickEn_q;
  logic cmdRemoteStart_q;
  logic cmdManualStart_q;
  logic cmdManualStop_q;
  logic cmdEmergencyStop_q;
  logic remoteStart_d;
  logic manualStart_d;
  logic manualStop_d;
  logic emergency_d;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then a one-cycle answer
  // ----------------------------------------------------------------
  assign regIdx = avs_address[4:2];
  assign wrDo = avs_write && !waitReq_q;
  assign loadDefaults = wrDo && avs_address == CONTROL_OFS && avs_byteenable[0]
                        && avs_writedata[LOAD_DEFAULTS_BIT];

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      waitReq_q <= 1'b1;
    end else begin
      waitReq_q <= !((avs_read || avs_write) && waitReq_q);
    end
  end

  always_comb begin
    rdData_d = BUS_WORD_RESET;
    if (avs_address[7:5] == IN_CFG_BASE[7:5]) begin
      rdData_d = {15'h0000, inPol_q[regIdx], inFunc_q[regIdx]};
    end else if (avs_address[7:5] == IN_DLY_BASE[7:5]) begin
      rdData_d = {16'h0000, inDelay_q[regIdx]};
    end else if (avs_address[7:5] == OUT_CFG_BASE[7:5]) begin
      rdData_d = {15'h0000, outPol_q[regIdx], outFunc_q[regIdx]};
    end else if (avs_address == STATUS_OFS) begin
      rdData_d = {11'h000, cmdEmergencyStop_q, cmdManualStop_q, cmdManualStart_q,
                  cmdRemoteStart_q, linkOnline, outPins_q, inQual};
    end
    if (avs_address[1:0] != 2'h0) begin
      rdData_d = BUS_WORD_RESET;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdData_q <= BUS_WORD_RESET;
    end else if (avs_read && waitReq_q) begin
      rdData_q <= rdData_d;
    end
  end

  assign avs_waitrequest = waitReq_q;
  assign avs_readdata = rdData_q;

  // ----------------------------------------------------------------
  // Configuration registers, reloaded by reset or a load of defaults
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst || loadDefaults) begin
      for (int i = 0; i < NIN; i++) begin
        inFunc_q[i] <= IN_FUNC_RESET[i*16 +: 16];
        inDelay_q[i] <= IN_DELAY_RESET;
        inPol_q[i] <= 1'b0;
      end
      for (int j = 0; j < NOUT; j++) begin
        outFunc_q[j] <= OUT_FUNC_RESET[j*16 +: 16];
        outPol_q[j] <= 1'b0;
      end
    end else if (wrDo && avs_address[1:0] == 2'h0) begin
      if (avs_address[7:5] == IN_CFG_BASE[7:5]) begin
        {inPol_q[regIdx], inFunc_q[regIdx]} <= 17'(mergeBytes(
          {15'h0000, inPol_q[regIdx], inFunc_q[regIdx]}, avs_writedata, avs_byteenable));
      end else if (avs_address[7:5] == IN_DLY_BASE[7:5]) begin
        inDelay_q[regIdx] <= 16'(mergeBytes({16'h0000, inDelay_q[regIdx]},
                                            avs_writedata, avs_byteenable));
      end else if (avs_address[7:5] == OUT_CFG_BASE[7:5]) begin
        {outPol_q[regIdx], outFunc_q[regIdx]} <= 17'(mergeBytes(
          {15'h0000, outPol_q[regIdx], outFunc_q[regIdx]}, avs_writedata, avs_byteenable));
      end
    end
  end

  // ----------------------------------------------------------------
  // Delay time base
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tickCnt_q <= 32'h0000_0000;
      tickEn_q <= 1'b0;
    end else if (tickCnt_q >= 32'(TICK_DIV - 1)) begin
      tickCnt_q <= 32'h0000_0000;
      tickEn_q <= 1'b1;
    end else begin
      tickCnt_q <= tickCnt_q + 32'h0000_0001;
      tickEn_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Input qualification and command decode
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NIN; i++) begin : gIn
    pifm_input_qualifier #(.DW(DELAY_W)) uQual (
      .sys_clk(sys_clk),
      .srst(srst),
      .rawIn(inPins[i]),
      .invert(inPol_q[i]),
      .tickEn(tickEn_q),
      .delay(inDelay_q[i]),
      .delayOnRelease(inFunc_q[i] == FN_REMOTE_START),
      .qualified(inQual[i])
    );
  end

  // Unused inputs never match a command code, so they stay silent.
  always_comb begin
    remoteStart_d = 1'b0;
    manualStart_d = 1'b0;
    manualStop_d = 1'b0;
    emergency_d = 1'b0;
    for (int i = 0; i < NIN; i++) begin
      remoteStart_d = remoteStart_d | (inQual[i] && inFunc_q[i] == FN_REMOTE_START);
      manualStart_d = manualStart_d | (inQual[i] && inFunc_q[i] == FN_MAN_START);
      manualStop_d = manualStop_d | (inQual[i] && inFunc_q[i] == FN_MAN_STOP);
      emergency_d = emergency_d | (inQual[i] && inFunc_q[i] == FN_EMERGENCY);
    end
  end

  // Command levels feed the link layer, which carries them over whichever
  // of the serial or network links is in use; this block is link neutral.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmdRemoteStart_q <= 1'b0;
      cmdManualStart_q <= 1'b0;
      cmdManualStop_q <= 1'b0;
      cmdEmergencyStop_q <= 1'b0;
    end else begin
      cmdRemoteStart_q <= remoteStart_d;
      cmdManualStart_q <= manualStart_d;
      cmdManualStop_q <= manualStop_d;
      cmdEmergencyStop_q <= emergency_d;
    end
  end

  assign cmdRemoteStart = cmdRemoteStart_q;
  assign cmdManualStart = cmdManualStart_q;
  assign cmdManualStop = cmdManualStop_q;
  assign cmdEmergencyStop = cmdEmergencyStop_q;

  // ----------------------------------------------------------------
  // Output functions
  // ----------------------------------------------------------------
  always_comb begin
    for (int j = 0; j < NOUT; j++) begin
      case (outFunc_q[j])
        FN_HORN: outResult[j] = hornRequest;
        FN_OFFLINE: outResult[j] = !linkOnline;
        default: outResult[j] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      outPins_q <= '0;
    end else begin
      outPins_q <= outResult ^ outPol_q;
    end
  end

  assign outPins = outPins_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic noCmdCodes;
  always_comb begin
    noCmdCodes = 1'b1;
    for (int i = 0; i < NIN; i++) begin
      if (inFunc_q[i] != FN_UNUSED) begin
        noCmdCodes = 1'b0;
      end
    end
  end

  sequence emergencyActive;
    inQual[0] && inFunc_q[0] == FN_EMERGENCY;
  endsequence

  ignore_unused_a: assert property (@(posedge sys_clk) disable iff (srst)
    noCmdCodes [*2] |-> !cmdRemoteStart && !cmdManualStart && !cmdManualStop
                        && !cmdEmergencyStop)
    else $error("Unused inputs raised a command.");

  forward_cmd_a: assert property (@(posedge sys_clk) disable iff (srst)
    emergencyActive |=> cmdEmergencyStop)
    else $error("Emergency input was not forwarded.");

  reset_defaults_a: assert property (@(posedge sys_clk)
    $fell(srst) |-> inFunc_q[0] == FN_EMERGENCY && inFunc_q[1] == FN_REMOTE_START
                    && inFunc_q[2] == FN_MAN_START && inFunc_q[3] == FN_MAN_STOP)
    else $error("Input defaults missing after reset.");

  out_defaults_a: assert property (@(posedge sys_clk)
    $fell(srst) |-> outFunc_q[6] == FN_OFFLINE && outFunc_q[7] == FN_HORN)
    else $error("Output defaults missing after reset.");

  offline_out_a: assert property (@(posedge sys_clk) disable iff (srst)
    outFunc_q[6] == FN_OFFLINE && !outPol_q[6] && !linkOnline |=> outPins[6])
    else $error("Offline output not asserted.");

  out_polarity_a: assert property (@(posedge sys_clk) disable iff (srst)
    outFunc_q[0] == FN_UNUSED |=> outPins[0] == $past(outPol_q[0]))
    else $error("Output polarity not applied.");

  bus_answer_a: assert property (@(posedge sys_clk) disable iff (srst)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("Bus answer not one cycle after the request.");
endmodule : pifm_panel_io
`default_nettype wire

// [dv/pifm_link_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// Stands in for the main controller: it reports link state and asks for the horn,
// each answer delayed by LAG cycles so that the panel never sees an instant reply.
module pifm_link_partner #(
  parameter int LAG = 3
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic setOnline,
  input wire logic setHorn,
  input wire logic cmdEmergencyStop,
  output logic linkOnline,
  output logic hornRequest
);
  logic [LAG-1:0] onPipe;
  logic [LAG-1:0] hornPipe;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      onPipe <= '0;
      hornPipe <= '0;
    end else begin
      onPipe <= {onPipe[LAG-2:0], setOnline};
      // A forwarded emergency stop makes the controller sound the horn.
      hornPipe <= {hornPipe[LAG-2:0], setHorn | cmdEmergencyStop};
    end
  end
  assign linkOnline = onPipe[LAG-1];
  assign hornRequest = hornPipe[LAG-1];
endmodule : pifm_link_partner
`default_nettype wire

// [dv/panel_io_function_mapper_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module panel_io_function_mapper_bench
  import pifm_pkg::*;
;
  localparam int TDIV = 4;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] avsAddress = 8'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [7:0] inPins = 8'h00;
  logic [7:0] outPins;
  logic linkOnline;
  logic hornRequest;
  logic setOnline = 1'b0;
  logic setHorn = 1'b0;
  logic [3:0] cmdVec;
  int fails = 0;
  int totalChecks = 0;
  logic [31:0] lfsr = 32'h851c;
  logic [31:0] q;
  logic [15:0] inDef [8] = '{FN_EMERGENCY, FN_REMOTE_START, FN_MAN_START, FN_MAN_STOP,
    FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED};
  logic [15:0] outDef [8] = '{FN_UNUSED, FN_UNUSED, FN_UNUSED, FN_UNUSED,
    FN_UNUSED, FN_UNUSED, FN_OFFLINE, FN_HORN};
  logic [15:0] mCode [8];
  logic mInv [8];
  logic [15:0] mOCode [8];
  logic mOInv [8];

  pifm_panel_io #(.TICK_DIV(TDIV)) uut (
    .sys_clk(sys_clk), .srst(srst), .avs_address(avsAddress), .avs_read(avsRead),
    .avs_write(avsWrite), .avs_writedata(avsWritedata), .avs_byteenable(4'hf),
    .avs_readdata(avsReaddata), .avs_waitrequest(avsWaitrequest), .inPins(inPins),
    .outPins(outPins), .linkOnline(linkOnline), .hornRequest(hornRequest),
    .cmdRemoteStart(cmdVec[0]), .cmdManualStart(cmdVec[1]), .cmdManualStop(cmdVec[2]),
    .cmdEmergencyStop(cmdVec[3]));

  pifm_link_partner partner (
    .sys_clk(sys_clk), .srst(srst), .setOnline(setOnline), .setHorn(setHorn),
    .cmdEmergencyStop(cmdVec[3]), .linkOnline(linkOnline), .hornRequest(hornRequest));

  always #5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Bus, model and comparison helpers
  // ----------------------------------------------------------------
  task close_out;
    if (fails == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // The request is held until waitrequest is seen low, however long that takes.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWritedata <= d;
    do begin
      @(posedge sys_clk);
    end while (avsWaitrequest !== 1'b0);
    q = avsReaddata;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus

  task load_model;
    for (int i = 0; i < 8; i++) begin
      mCode[i] = inDef[i];
      mInv[i] = 1'b0;
      mOCode[i] = outDef[i];
      mOInv[i] = 1'b0;
    end
  endtask : load_model

  task cfg_in(input int i, input logic [15:0] code, input logic inv, input logic [15:0] dly);
    bus(1'b1, IN_CFG_BASE + 8'(4 * i), {15'h0, inv, code});
    bus(1'b1, IN_DLY_BASE + 8'(4 * i), {16'h0, dly});
    mCode[i] = code;
    mInv[i] = inv;
  endtask : cfg_in

  task cfg_out(input int j, input logic [15:0] code, input logic inv);
    bus(1'b1, OUT_CFG_BASE + 8'(4 * j), {15'h0, inv, code});
    mOCode[j] = code;
    mOInv[j] = inv;
  endtask : cfg_out

  task check_all;
    logic [3:0] c;
    logic [7:0] o;
    logic [7:0] lv;
    logic h;
    c = 4'h0;
    for (int i = 0; i < 8; i++) begin
      lv[i] = inPins[i] ^ mInv[i];
      if (lv[i]) begin
        case (mCode[i])
          FN_REMOTE_START: c[0] = 1'b1;
          FN_MAN_START: c[1] = 1'b1;
          FN_MAN_STOP: c[2] = 1'b1;
          FN_EMERGENCY: c[3] = 1'b1;
          default: ;
        endcase
      end
    end
    h = setHorn | c[3];
    for (int j = 0; j < 8; j++) begin
      o[j] = mOInv[j] ^ ((mOCode[j] == FN_HORN) ? h :
                         (mOCode[j] == FN_OFFLINE) ? !setOnline : 1'b0);
    end
    chk({28'h0, cmdVec}, {28'h0, c});
    chk({24'h0, outPins}, {24'h0, o});
    // Inputs stay put during the status read, so the snapshot must match the model.
    bus(1'b0, STATUS_OFS, 32'h0);
    chk(q, {11'h0, c, setOnline, o, lv});
  endtask : check_all

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_step

  task rand_run(input int n);
    for (int k = 0; k < n; k++) begin
      lfsr = lfsr_step(lfsr);
      inPins <= lfsr[7:0];
      setOnline <= lfsr[8];
      setHorn <= lfsr[9];
      repeat (10) @(posedge sys_clk);
      check_all();
    end
  endtask : rand_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    load_model();
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, IN_CFG_BASE + 8'(4 * i), 32'h0);
      chk(q, {16'h0, inDef[i]});
      bus(1'b0, OUT_CFG_BASE + 8'(4 * i), 32'h0);
      chk(q, {16'h0, outDef[i]});
    end
    bus(1'b0, 8'h84, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 8'h01, 32'h0001_0000);
    rand_run(30);
    cfg_in(0, FN_EMERGENCY, 1'b1, 16'h0);
    cfg_in(4, FN_MAN_STOP, 1'b1, 16'h0);
    cfg_in(5, 16'h1234, 1'b0, 16'h0);
    cfg_in(7, FN_REMOTE_START, 1'b0, 16'h0);
    cfg_out(0, FN_HORN, 1'b1);
    cfg_out(1, FN_OFFLINE, 1'b0);
    cfg_out(2, FN_UNUSED, 1'b1);
    cfg_out(7, FN_OFFLINE, 1'b1);
    rand_run(30);
    bus(1'b1, CONTROL_OFS, 32'h1);
    load_model();
    bus(1'b0, IN_CFG_BASE, 32'h0);
    chk(q, {16'h0, FN_EMERGENCY});
    inPins <= 8'h00;
    cfg_in(1, FN_REMOTE_START, 1'b0, 16'h3);
    cfg_in(2, FN_MAN_START, 1'b0, 16'h3);
    repeat (10) @(posedge sys_clk);
    // Three ticks of four cycles, up to one tick shorter depending on the tick phase.
    inPins <= 8'h06;
    repeat (4) @(posedge sys_clk);
    chk({28'h0, cmdVec}, 32'h0);
    repeat (20) @(posedge sys_clk);
    chk({28'h0, cmdVec}, 32'h3);
    inPins <= 8'h00;
    repeat (4) @(posedge sys_clk);
    chk({28'h0, cmdVec}, 32'h1);
    repeat (20) @(posedge sys_clk);
    chk({28'h0, cmdVec}, 32'h0);
    // With every input unused, no pin pattern may raise any command.
    for (int i = 0; i < 4; i++) begin
      cfg_in(i, FN_UNUSED, 1'b1, 16'h0);
    end
    rand_run(5);
    close_out();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    close_out();
  end
endmodule : panel_io_function_mapper_bench
`default_nettype wire
